// ===== rtl/irq_ctrl_consts.svh
`ifndef IRQ_CTRL_CONSTS_SVH
`define IRQ_CTRL_CONSTS_SVH
// =====================================================================
// Register word indexes; the byte address is four times the index.
`define CORE_IRQ_CONTROL_IDX     8'h0b
`define PERIPH_REQ_FLAGS_A_IDX   8'h0c
`define PERIPH_REQ_FLAGS_B_IDX   8'h0d
`define PERIPH_ENABLE_A_IDX      8'h8c
`define PERIPH_ENABLE_B_IDX      8'h8d
// =====================================================================
// Core control register bit positions.
`define BIT_GLOBAL_EN    7
`define BIT_PERIPH_EN    6
`define BIT_T0_EN        5
`define BIT_EXT_EN       4
`define BIT_PB_EN        3
`define BIT_T0_FLAG      2
`define BIT_EXT_FLAG     1
`define BIT_PB_FLAG      0
// =====================================================================
// Peripheral register A bit positions (flags and enables share them).
`define BIT_ADC          6
`define BIT_RX           5
`define BIT_TX           4
`define BIT_CCP1         2
`define BIT_TMR2         1
`define BIT_T1_OVF       0
// Peripheral register B bit positions.
`define BIT_TOUCH        6
`define BIT_PA           5
`define BIT_NVM          4
`define BIT_CCP2         0
// =====================================================================
// Implemented bit masks and reset values.
`define MASK_A           8'h77
`define MASK_B           8'h71
`define RESET_REG        8'h00
`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10
`define VECTOR_ADDR      13'h0004
`endif

// ===== rtl/irq_ctrl_pkg.sv
package irq_ctrl_pkg;
    // Event pulses from the peripherals, one cycle each.
    typedef struct packed {
        logic timer0_ovf;     // Timer 0 wrapped.
        logic ext_pin_edge;   // Selected edge seen on external pin.
        logic portb_change;   // Port B level change.
        logic converter_done; // Conversion finished.
        logic capcmp_one;     // First capture/compare event.
        logic timer2_match;   // Timer 2 hit its period.
        logic timer1_ovf;     // Timer 1 wrapped.
        logic touch_done;     // Touch scan finished.
        logic porta_change;   // Port A level change.
        logic prog_nvm_write; // Program memory write finished.
        logic capcmp_two;     // Second capture/compare event.
    } irq_events_t;

    // Bus answer state.
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_RESP = 2'b01
    } bus_state_t;
endpackage

// ===== rtl/mcu_interrupt_control.sv
`timescale 1ns/1ns
`include "irq_ctrl_consts.svh"
module mcu_interrupt_control
    import irq_ctrl_pkg::*;
(
    input  wire logic        aclk,            // System clock, 10 MHz.
    input  wire logic        aresetn,         // Synchronous reset, active low.
    input  wire logic [31:0] s_axi_awaddr,    // Write address.
    input  wire logic        s_axi_awvalid,   // Write address valid.
    output logic             s_axi_awready,   // Write address ready.
    input  wire logic [31:0] s_axi_wdata,     // Write data.
    input  wire logic [3:0]  s_axi_wstrb,     // Write byte strobes.
    input  wire logic        s_axi_wvalid,    // Write data valid.
    output logic             s_axi_wready,    // Write data ready.
    output logic [1:0]       s_axi_bresp,     // Write response.
    output logic             s_axi_bvalid,    // Write response valid.
    input  wire logic        s_axi_bready,    // Write response ready.
    input  wire logic [31:0] s_axi_araddr,    // Read address.
    input  wire logic        s_axi_arvalid,   // Read address valid.
    output logic             s_axi_arready,   // Read address ready.
    output logic [31:0]      s_axi_rdata,     // Read data.
    output logic [1:0]       s_axi_rresp,     // Read response.
    output logic             s_axi_rvalid,    // Read response valid.
    input  wire logic        s_axi_rready,    // Read response ready.
    input  wire irq_events_t events,          // Peripheral event pulses.
    input  wire logic        rx_buffer_full,  // Receive buffer holds data.
    input  wire logic        tx_buffer_empty, // Transmit buffer is empty.
    input  wire logic        irq_accept,      // Core takes the request, pulse.
    input  wire logic        irq_return,      // Core executes return, pulse.
    output logic             irq_request,     // Request to the core.
    output logic             irq_in_service,  // A handler is running.
    output logic [12:0]      irq_vector       // Fixed vector address.
);

    // =====================================================================
    // State registers.
    logic [7:0]  ctrl_q, ctrl_d;       // Core control: enables and core flags.
    logic [7:0]  flags_a_q, flags_a_d; // Peripheral flags A, bits 5,4 stay zero.
    logic [7:0]  flags_b_q, flags_b_d; // Peripheral flags B.
    logic [7:0]  en_a_q, en_a_d;       // Peripheral enables A.
    logic [7:0]  en_b_q, en_b_d;       // Peripheral enables B.
    logic        serv_q, serv_d;       // Handler active.
    logic        req_q, req_d;         // Registered request output.
    bus_state_t  wst_q, wst_d;         // Write channel state.
    bus_state_t  rst_q, rst_d;         // Read channel state.
    logic [1:0]  bresp_q, bresp_d;     // Write response code.
    logic [31:0] rdata_q, rdata_d;     // Read data.
    logic [1:0]  rresp_q, rresp_d;     // Read response code.
    logic        aw_seen_q, aw_seen_d; // Write address captured.
    logic        w_seen_q, w_seen_d;   // Write data captured.
    logic [31:0] awaddr_q, awaddr_d;   // Captured write address.
    logic [31:0] wdata_q, wdata_d;     // Captured write data.
    logic        wstrb0_q, wstrb0_d;   // Captured low lane strobe.

    // Word index of a byte address; bits above bit 9 are unused.
    function automatic logic [7:0] word_idx(input logic [31:0] a);
        word_idx = a[9:2];
    endfunction

    // A mapped address has zero low bits, zero bits above bit 9 and a known index.
    function automatic logic mapped(input logic [31:0] a);
        logic [7:0] i;
        i = word_idx(a);
        mapped = (a[1:0] == 2'b00) && (a[31:10] == 22'h000000) &&
                 (i == `CORE_IRQ_CONTROL_IDX || i == `PERIPH_REQ_FLAGS_A_IDX ||
                  i == `PERIPH_REQ_FLAGS_B_IDX || i == `PERIPH_ENABLE_A_IDX ||
                  i == `PERIPH_ENABLE_B_IDX);
    endfunction

    // Live read-only bits of flags A come straight from the serial unit.
    logic [7:0] flags_a_view;
    logic       do_write;
    logic       rd_take;
    logic       core_pend;
    logic       peri_pend;

    // =====================================================================
    // Bus write side: address and data may come in either order.
    always_comb begin
        wst_d     = wst_q;
        aw_seen_d = aw_seen_q;
        w_seen_d  = w_seen_q;
        awaddr_d  = awaddr_q;
        wdata_d   = wdata_q;
        wstrb0_d  = wstrb0_q;
        bresp_d   = bresp_q;
        do_write  = 1'b0;
        case (wst_q)
            BUS_IDLE: begin
                if (s_axi_awvalid && !aw_seen_q) begin
                    aw_seen_d = 1'b1;
                    awaddr_d  = s_axi_awaddr;
                end
                if (s_axi_wvalid && !w_seen_q) begin
                    w_seen_d = 1'b1;
                    wdata_d  = s_axi_wdata;
                    wstrb0_d = s_axi_wstrb[0];
                end
                // Both halves held: commit and answer next cycle.
                if (aw_seen_q && w_seen_q) begin
                    do_write  = 1'b1;
                    bresp_d   = mapped(awaddr_q) ? `RESP_OKAY : `RESP_SLVERR;
                    aw_seen_d = 1'b0;
                    w_seen_d  = 1'b0;
                    wst_d     = BUS_RESP;
                end
            end
            BUS_RESP: begin
                if (s_axi_bready) begin
                    wst_d = BUS_IDLE;
                end
            end
            default: begin
                wst_d = BUS_IDLE;
            end
        endcase
    end

    // =====================================================================
    // Bus read side: one read at a time, data captured when taken.
    always_comb begin
        rst_d   = rst_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        rd_take = 1'b0;
        case (rst_q)
            BUS_IDLE: begin
                if (s_axi_arvalid) begin
                    rd_take = 1'b1;
                    rresp_d = mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
                    case (word_idx(s_axi_araddr))
                        `CORE_IRQ_CONTROL_IDX:   rdata_d = {24'h000000, ctrl_q};
                        `PERIPH_REQ_FLAGS_A_IDX: rdata_d = {24'h000000, flags_a_view};
                        `PERIPH_REQ_FLAGS_B_IDX: rdata_d = {24'h000000, flags_b_q};
                        `PERIPH_ENABLE_A_IDX:    rdata_d = {24'h000000, en_a_q};
                        `PERIPH_ENABLE_B_IDX:    rdata_d = {24'h000000, en_b_q};
                        default:                 rdata_d = 32'h00000000;
                    endcase
                    if (!mapped(s_axi_araddr)) begin
                        rdata_d = 32'h00000000;
                    end
                    rst_d = BUS_RESP;
                end
            end
            BUS_RESP: begin
                if (s_axi_rready) begin
                    rst_d = BUS_IDLE;
                end
            end
            default: begin
                rst_d = BUS_IDLE;
            end
        endcase
    end

    // Receive and transmit flags are views of buffer state, never stored.
    always_comb begin
        flags_a_view            = flags_a_q;
        flags_a_view[`BIT_RX]   = rx_buffer_full;
        flags_a_view[`BIT_TX]   = tx_buffer_empty;
    end

    // =====================================================================
    // Flags and enables. Software writes first, then hardware sets on top,
    // so an event landing with a clearing write is never lost.
    always_comb begin
        logic wr_ok;
        logic [7:0] widx;
        wr_ok     = do_write && wstrb0_q && mapped(awaddr_q);
        widx      = word_idx(awaddr_q);
        ctrl_d    = ctrl_q;
        flags_a_d = flags_a_q;
        flags_b_d = flags_b_q;
        en_a_d    = en_a_q;
        en_b_d    = en_b_q;
        serv_d    = serv_q;
        if (wr_ok) begin
            case (widx)
                `CORE_IRQ_CONTROL_IDX:   ctrl_d    = wdata_q[7:0];
                // Receive and transmit bits are read-only and are not kept.
                `PERIPH_REQ_FLAGS_A_IDX: flags_a_d = wdata_q[7:0] & `MASK_A & 8'hcf;
                `PERIPH_REQ_FLAGS_B_IDX: flags_b_d = wdata_q[7:0] & `MASK_B;
                `PERIPH_ENABLE_A_IDX:    en_a_d    = wdata_q[7:0] & `MASK_A;
                `PERIPH_ENABLE_B_IDX:    en_b_d    = wdata_q[7:0] & `MASK_B;
                default:                 ctrl_d    = ctrl_q;
            endcase
        end
        // Return reopens the gate; acceptance closes it and enters service.
        if (irq_return) begin
            ctrl_d[`BIT_GLOBAL_EN] = 1'b1;
            serv_d                 = 1'b0;
        end
        if (irq_accept && req_q) begin
            ctrl_d[`BIT_GLOBAL_EN] = 1'b0;
            serv_d                 = 1'b1;
        end
        // Sticky event capture, independent of every enable.
        if (events.timer0_ovf)     ctrl_d[`BIT_T0_FLAG]     = 1'b1;
        if (events.ext_pin_edge)   ctrl_d[`BIT_EXT_FLAG]    = 1'b1;
        if (events.portb_change)   ctrl_d[`BIT_PB_FLAG]     = 1'b1;
        if (events.converter_done) flags_a_d[`BIT_ADC]      = 1'b1;
        if (events.capcmp_one)     flags_a_d[`BIT_CCP1]     = 1'b1;
        if (events.timer2_match)   flags_a_d[`BIT_TMR2]     = 1'b1;
        if (events.timer1_ovf)     flags_a_d[`BIT_T1_OVF]   = 1'b1;
        if (events.touch_done)     flags_b_d[`BIT_TOUCH]    = 1'b1;
        if (events.porta_change)   flags_b_d[`BIT_PA]       = 1'b1;
        if (events.prog_nvm_write) flags_b_d[`BIT_NVM]      = 1'b1;
        if (events.capcmp_two)     flags_b_d[`BIT_CCP2]     = 1'b1;
    end

    // =====================================================================
    // Request: one shared line, equal priority, software polls the flags.
    always_comb begin
        core_pend = (ctrl_q[`BIT_T0_EN]  & ctrl_q[`BIT_T0_FLAG]) |
                    (ctrl_q[`BIT_EXT_EN] & ctrl_q[`BIT_EXT_FLAG]) |
                    (ctrl_q[`BIT_PB_EN]  & ctrl_q[`BIT_PB_FLAG]);
        peri_pend = ctrl_q[`BIT_PERIPH_EN] &
                    (|(flags_a_view & en_a_q) | |(flags_b_q & en_b_q));
        // Handler state also holds off a request until return.
        req_d = ctrl_d[`BIT_GLOBAL_EN] & (core_pend | peri_pend) &
                ~serv_d & ~(irq_accept && req_q);
    end

    // =====================================================================
    // Register everything; one flop stage per output.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q    <= `RESET_REG;
            flags_a_q <= `RESET_REG;
            flags_b_q <= `RESET_REG;
            en_a_q    <= `RESET_REG;
            en_b_q    <= `RESET_REG;
            serv_q    <= 1'b0;
            req_q     <= 1'b0;
            wst_q     <= BUS_IDLE;
            rst_q     <= BUS_IDLE;
            bresp_q   <= `RESP_OKAY;
            rdata_q   <= 32'h00000000;
            rresp_q   <= `RESP_OKAY;
            aw_seen_q <= 1'b0;
            w_seen_q  <= 1'b0;
            awaddr_q  <= 32'h00000000;
            wdata_q   <= 32'h00000000;
            wstrb0_q  <= 1'b0;
        end else begin
            ctrl_q    <= ctrl_d;
            flags_a_q <= flags_a_d;
            flags_b_q <= flags_b_d;
            en_a_q    <= en_a_d;
            en_b_q    <= en_b_d;
            serv_q    <= serv_d;
            req_q     <= req_d;
            wst_q     <= wst_d;
            rst_q     <= rst_d;
            bresp_q   <= bresp_d;
            rdata_q   <= rdata_d;
            rresp_q   <= rresp_d;
            aw_seen_q <= aw_seen_d;
            w_seen_q  <= w_seen_d;
            awaddr_q  <= awaddr_d;
            wdata_q   <= wdata_d;
            wstrb0_q  <= wstrb0_d;
        end
    end

    // Ready is high while the channel has room; these are decoded from flops only, with no path from the inputs.
    assign s_axi_awready  = ~aw_seen_q & (wst_q == BUS_IDLE);
    assign s_axi_wready   = ~w_seen_q & (wst_q == BUS_IDLE);
    assign s_axi_bvalid   = (wst_q == BUS_RESP);
    assign s_axi_bresp    = bresp_q;
    assign s_axi_arready  = (rst_q == BUS_IDLE);
    assign s_axi_rvalid   = (rst_q == BUS_RESP);
    assign s_axi_rdata    = rdata_q;
    assign s_axi_rresp    = rresp_q;
    assign irq_request    = req_q;
    assign irq_in_service = serv_q;
    // The core jumps here; no context is saved by this block.
    assign irq_vector     = `VECTOR_ADDR;

    // =====================================================================
    // Checks.
    property p_flag_set;
        @(posedge aclk) disable iff (!aresetn)
        events.timer1_ovf |=> flags_a_q[`BIT_T1_OVF];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("timer1 flag not set");

    property p_global_block;
        @(posedge aclk) disable iff (!aresetn)
        !ctrl_q[`BIT_GLOBAL_EN] |-> !irq_request;
    endproperty
    a_global_block: assert property (p_global_block) else $error("request without global enable");

    property p_accept_clears;
        @(posedge aclk) disable iff (!aresetn)
        (irq_accept && req_q && !irq_return) |=> !ctrl_q[`BIT_GLOBAL_EN] && irq_in_service;
    endproperty
    a_accept_clears: assert property (p_accept_clears) else $error("accept did not close gate");

    property p_return_sets;
        @(posedge aclk) disable iff (!aresetn)
        (irq_return && !irq_accept) |=> ctrl_q[`BIT_GLOBAL_EN] && !irq_in_service;
    endproperty
    a_return_sets: assert property (p_return_sets) else $error("return did not reopen");

    property p_no_nest;
        @(posedge aclk) disable iff (!aresetn)
        irq_in_service |-> !irq_request;
    endproperty
    a_no_nest: assert property (p_no_nest) else $error("request during service");

    property p_t0_req;
        @(posedge aclk) disable iff (!aresetn)
        (ctrl_q[`BIT_GLOBAL_EN] && ctrl_q[`BIT_T0_EN] && ctrl_q[`BIT_T0_FLAG] && !serv_q &&
         !irq_accept && !irq_return && ctrl_d[`BIT_GLOBAL_EN]) |=> irq_request;
    endproperty
    a_t0_req: assert property (p_t0_req) else $error("timer0 request missing");

    property p_periph_gate;
        @(posedge aclk) disable iff (!aresetn)
        (!ctrl_q[`BIT_PERIPH_EN] && core_pend == 1'b0) |-> !peri_pend;
    endproperty
    a_periph_gate: assert property (p_periph_gate) else $error("peripheral not gated");

    property p_rx_view;
        @(posedge aclk) disable iff (!aresetn)
        (rd_take && word_idx(s_axi_araddr) == `PERIPH_REQ_FLAGS_A_IDX && s_axi_araddr[1:0] == 2'b00 &&
         s_axi_araddr[31:10] == 22'h000000) |=> s_axi_rdata[`BIT_RX] == $past(rx_buffer_full);
    endproperty
    a_rx_view: assert property (p_rx_view) else $error("receive flag view wrong");

    property p_vector;
        @(posedge aclk) disable iff (!aresetn)
        irq_request |-> irq_vector == `VECTOR_ADDR;
    endproperty
    a_vector: assert property (p_vector) else $error("vector address wrong");

endmodule

// ===== sim/core_model.sv
`timescale 1ns/1ns
// ==========================================
// Core stand-in: takes a request after a set wait, runs a handler of set length, then returns.
module core_model (
    input  wire logic       aclk,        // System clock.
    input  wire logic       aresetn,     // Synchronous reset, active low.
    input  wire logic       core_on,     // Core may take requests.
    input  wire logic [7:0] take_wait,   // Cycles of request seen before taking it.
    input  wire logic [7:0] stay_cycles, // Length of the handler in cycles.
    input  wire logic       irq_request, // Request from the block.
    output logic            irq_accept,  // One-cycle take pulse.
    output logic            irq_return   // One-cycle return pulse.
);
    logic [7:0] cnt_q, cnt_d;   // Wait and handler counter.
    logic       busy_q, busy_d; // Handler is running.
    logic       take_q, take_d; // Take pulse register.
    logic       ret_q, ret_d;   // Return pulse register.

    // One handler at a time; a request that drops before the wait ends is not taken.
    always_comb begin
        cnt_d = cnt_q + 8'h01;
        busy_d = busy_q;
        take_d = 1'b0;
        ret_d = 1'b0;
        if (!busy_q && !(core_on && irq_request)) begin
            cnt_d = 8'h00;
        end else if (!busy_q && cnt_q >= take_wait) begin
            take_d = 1'b1;
            busy_d = 1'b1;
            cnt_d = 8'h00;
        end else if (busy_q && cnt_q >= stay_cycles) begin
            ret_d = 1'b1;
            busy_d = 1'b0;
            cnt_d = 8'h00;
        end
    end

    // Registers only.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= 8'h00;
            busy_q <= 1'b0;
            take_q <= 1'b0;
            ret_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            busy_q <= busy_d;
            take_q <= take_d;
            ret_q <= ret_d;
        end
    end

    assign irq_accept = take_q;
    assign irq_return = ret_q;
endmodule

// ===== sim/mcu_interrupt_control_tb_top.sv
`timescale 1ns/1ns
// ==========================================
// Bench: bus tasks, a walk over every source, then serviced interrupts.
module mcu_interrupt_control_tb_top
    import irq_ctrl_pkg::*;
;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb = '0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    irq_events_t events = '0;
    logic        rx_buffer_full = 1'b0, tx_buffer_empty = 1'b0, core_on = 1'b0;
    logic        irq_accept, irq_return, irq_request, irq_in_service;
    logic [12:0] irq_vector;
    logic [7:0]  take_wait = 8'h00;
    int          num_errors = 0, checked = 0;
    // Sources in package order: flag register byte address and flag bit.
    logic [31:0] flag_addr [11] = '{32'h2c, 32'h2c, 32'h2c, 32'h30, 32'h30, 32'h30, 32'h30, 32'h34, 32'h34, 32'h34,
                                    32'h34};
    int          flag_bit [11] = '{2, 1, 0, 6, 2, 1, 0, 6, 5, 4, 0};
    logic [31:0] reg_addr [5] = '{32'h2c, 32'h30, 32'h34, 32'h230, 32'h234};

    always #50 aclk = ~aclk;

    mcu_interrupt_control u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .events,
        .rx_buffer_full, .tx_buffer_empty, .irq_accept, .irq_return, .irq_request, .irq_in_service, .irq_vector);

    core_model u_core (.aclk, .aresetn, .core_on, .take_wait, .stay_cycles(8'h3c), .irq_request, .irq_accept,
        .irq_return);

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Address and data go out together; each is dropped once taken.
    task automatic bus_write(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
        logic aw_done, w_done;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        aw_done = 1'b0;
        w_done = 1'b0;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (!aw_done && s_axi_awready) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (s_axi_bvalid !== 1'b1) @(posedge aclk);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic bus_read(input logic [31:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // One-cycle event on source k; source 0 sits in the top bit of the struct.
    task automatic pulse(input int k);
        irq_events_t v;
        v = '0;
        v[$bits(irq_events_t)-1-k] = 1'b1;
        @(posedge aclk);
        events <= v;
        @(posedge aclk);
        events <= '0;
        repeat (2) @(posedge aclk);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Whole run is under 1000 cycles; the limit leaves wide room.
    initial begin
        #(100 * 30000);
        num_errors++;
        $display("mismatch watchdog expected finish seen timeout");
        tally_and_finish();
    end

    initial begin
        logic        core;
        int          n;
        logic [31:0] fb, eb;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            bus_read(reg_addr[i]);
            chk("reset value", 32'h0, rd);
        end
        bus_read(32'h40);
        chk("unmapped read resp", 32'h2, resp);
        chk("unmapped read data", 32'h0, rd);
        bus_write(32'h44, 32'hff, 4'hf);
        chk("unmapped write resp", 32'h2, resp);
        bus_write(32'h2c, 32'hff, 4'h0);
        chk("write resp", 32'h0, resp);
        bus_read(32'h2c);
        chk("strobe off write", 32'h0, rd);
        $display("test reset_and_bus done");
        // Serial flags follow the buffer levels and ignore writes.
        rx_buffer_full <= 1'b1;
        tx_buffer_empty <= 1'b1;
        bus_write(32'h30, 32'h0, 4'hf);
        bus_read(32'h30);
        chk("serial flags", 32'h30, rd);
        rx_buffer_full <= 1'b0;
        bus_read(32'h30);
        chk("rx flag drop", 32'h10, rd);
        tx_buffer_empty <= 1'b0;
        $display("test serial_flags done");
        // Every source: set while disabled, gated, requested, then cleared.
        for (int k = 0; k < 11; k++) begin
            core = (flag_addr[k] == 32'h2c);
            fb = 32'h1 << flag_bit[k];
            eb = core ? fb << 3 : fb;
            pulse(k);
            bus_read(flag_addr[k]);
            chk("flag set while disabled", fb, rd);
            chk("request while disabled", 32'h0, irq_request);
            if (!core) bus_write(flag_addr[k] + 32'h200, eb, 4'hf);
            bus_write(32'h2c, core ? 32'h40 | eb | fb : 32'h80, 4'hf);
            // Let the written enables reach the request flop before looking.
            repeat (2) @(posedge aclk);
            chk("request gated", 32'h0, irq_request);
            bus_write(32'h2c, 32'hc0 | (core ? eb | fb : 32'h0), 4'hf);
            repeat (2) @(posedge aclk);
            chk("request enabled", 32'h1, irq_request);
            bus_write(flag_addr[k], core ? 32'hc0 | eb : 32'h0, 4'hf);
            repeat (2) @(posedge aclk);
            chk("request after clear", 32'h0, irq_request);
            if (!core) bus_write(flag_addr[k] + 32'h200, 32'h0, 4'hf);
            bus_write(32'h2c, 32'h0, 4'hf);
        end
        $display("test source_walk done");
        // Taken request, service without nesting, return; prompt then slow core.
        for (int r = 0; r < 2; r++) begin
            take_wait <= r ? 8'h05 : 8'h00;
            core_on <= 1'b1;
            bus_write(32'h2c, 32'h20, 4'hf);
            bus_write(32'h2c, 32'ha0, 4'hf);
            pulse(0);
            n = 0;
            while (irq_accept !== 1'b1 && n < 50) begin
                @(posedge aclk);
                n++;
            end
            chk("accept seen", 32'h1, irq_accept);
            repeat (2) @(posedge aclk);
            chk("in service", 32'h1, irq_in_service);
            chk("vector", 32'h4, irq_vector);
            bus_read(32'h2c);
            chk("control in service", 32'h24, rd);
            pulse(0);
            // Software reopens the global gate in the handler; service alone must hold the line low.
            bus_write(32'h2c, 32'ha4, 4'hf);
            repeat (2) @(posedge aclk);
            chk("request in service", 32'h0, irq_request);
            bus_write(32'h2c, 32'h20, 4'hf);
            n = 0;
            while (irq_return !== 1'b1 && n < 100) begin
                @(posedge aclk);
                n++;
            end
            chk("return seen", 32'h1, irq_return);
            repeat (2) @(posedge aclk);
            chk("service ended", 32'h0, irq_in_service);
            bus_read(32'h2c);
            chk("control after return", 32'ha0, rd);
            chk("no request after return", 32'h0, irq_request);
            core_on <= 1'b0;
            bus_write(32'h2c, 32'h0, 4'hf);
        end
        $display("test service done");
        tally_and_finish();
    end
endmodule
